// file: logic/pwr_defines.vh
// Purpose: constants for the transceiver power state control block
// Assumes: 25 MHz clk_sys, AXI4-Lite register access, 32-bit data
// Notes:   offsets are byte addresses, one word per register
`ifndef PWR_DEFINES_VH
`define PWR_DEFINES_VH

// register byte offsets
`define OFS_MODE        8'h00
`define OFS_STATUS      8'h04
`define OFS_IRQ_STAT    8'h08
`define OFS_IRQ_MASK    8'h0C

// mode codes
`define MODE_PD         4'h0
`define MODE_DS         4'h1
`define MODE_STBY       4'h5
`define MODE_FIFO       4'h6
`define MODE_SYNRX      4'h8
`define MODE_RX         4'h9
`define MODE_WOR        4'hB
`define MODE_SYNTX      4'hC
`define MODE_TX         4'hD
`define MODE_RST        4'h0

// status word fields
`define ST_REG_RDY      0
`define ST_BROWN        1
`define ST_PEND         2
`define ST_FIFO_EN      3
`define ST_MODE_LO      4
`define ST_MODE_HI      7

// interrupt event bits
`define IRQ_W           3
`define EV_REG_RDY      0
`define EV_BROWN        1
`define EV_MODE         2
`define IRQ_RST         3'h0

// bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// timing
`define CLK_PERIOD_NS   40
`define REG_SETTLE_NS   20000
`define INIT_NS         100000
`define REG_SETTLE_CYC  ((`REG_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_CYC        ((`INIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: logic/supply_seq.v
// Purpose: supply and regulator enables per applied power mode
// Assumes: mode comes from a register on the same clock
// Notes:   ready restarts whenever the core supplies switch on
`timescale 1ns/100ps
`include "pwr_defines.vh"
module supply_seq #(
	parameter SETTLE_CYC = `REG_SETTLE_CYC,
	parameter CNT_W      = 12
) (
	// clock and reset
	input  wire       clk_sys,
	input  wire       rst,
	// applied mode
	input  wire [3:0] mode,
	// supply enables
	output reg        dig_on_ff,
	output reg        ana_on_ff,
	output reg        xtal_on_ff,
	output reg        synth_on_ff,
	output reg        rx_on_ff,
	output reg        tx_on_ff,
	output reg        reg_ready_ff
);
	localparam [CNT_W-1:0] LAST = SETTLE_CYC[CNT_W-1:0] - 1'b1;
	reg  [CNT_W-1:0] cnt_ff;
	reg  [5:0]       nxt_en;
	wire             core_on;

	// low-leakage, deep sleep and wake-on-radio keep the core off
	always @* begin
		case (mode)
			`MODE_STBY:  nxt_en = 6'h07;
			`MODE_FIFO:  nxt_en = 6'h05;
			`MODE_SYNRX: nxt_en = 6'h0F;
			`MODE_RX:    nxt_en = 6'h1F;
			`MODE_SYNTX: nxt_en = 6'h0F;
			`MODE_TX:    nxt_en = 6'h2F;
			default:     nxt_en = 6'h00;
		endcase
	end

	assign core_on = nxt_en[0] | nxt_en[1];

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{tx_on_ff, rx_on_ff, synth_on_ff} <= 3'h0;
			{xtal_on_ff, ana_on_ff, dig_on_ff} <= 3'h0;
			cnt_ff       <= {CNT_W{1'b0}};
			reg_ready_ff <= 1'b0;
		end else begin
			{tx_on_ff, rx_on_ff, synth_on_ff} <= nxt_en[5:3];
			{xtal_on_ff, ana_on_ff, dig_on_ff} <= nxt_en[2:0];
			// regulators settle from switch-on, not from every mode step
			if (!core_on) begin
				cnt_ff       <= {CNT_W{1'b0}};
				reg_ready_ff <= 1'b0;
			end else if (cnt_ff != LAST) begin
				cnt_ff <= cnt_ff + 1'b1;
			end else begin
				reg_ready_ff <= 1'b1;
			end
		end
	end
endmodule

// file: logic/xcvr_power_ctrl.v
// Purpose: transceiver power state control with AXI4-Lite registers
// Assumes: fifo_empty comes from FIFO logic on clk_sys
// Notes:   brown-out and select pins are asynchronous and synchronised
`timescale 1ns/100ps
`include "pwr_defines.vh"
module xcvr_power_ctrl #(
	parameter SETTLE_CYC = `REG_SETTLE_CYC,
	parameter INIT_CYC   = `INIT_CYC,
	parameter CNT_W      = 12
) (
	// clock and reset
	input  wire        clk_sys,
	input  wire        rst,
	// axi4-lite write address
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [7:0]  s_axi_awaddr,
	// axi4-lite write data
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	output reg  [1:0]  s_axi_bresp,
	// axi4-lite read address
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	input  wire [7:0]  s_axi_araddr,
	// axi4-lite read data
	input  wire        s_axi_rready,
	output reg         s_axi_rvalid,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	// pins
	input  wire        io_below_bo,
	input  wire        sel_n,
	output reg         sdo_ready_ff,
	// fifo side
	input  wire        fifo_empty,
	output reg         fifo_access_en_ff,
	output reg         fifo_flush_ff,
	// supply enables
	output wire        core_dig_on,
	output wire        core_ana_on,
	output wire        xtal_on,
	output wire        synth_on,
	output wire        rx_on,
	output wire        tx_on,
	// interrupt
	output reg         irq_ff
);
	localparam [CNT_W-1:0] INIT_LAST = INIT_CYC[CNT_W-1:0] - 1'b1;

	// wake and init states
	localparam [1:0] ST_RUN   = 2'h0;
	localparam [1:0] ST_SLEEP = 2'h1;
	localparam [1:0] ST_INIT  = 2'h2;

	reg  [1:0]       state_ff;
	reg  [CNT_W-1:0] init_cnt_ff;
	reg  [3:0]       mode_req_ff;
	reg  [3:0]       mode_cur_ff;
	reg              pend_ff;
	reg  [`IRQ_W-1:0] irq_stat_ff;
	reg  [`IRQ_W-1:0] irq_mask_ff;
	reg  [1:0]       bo_sync_ff;
	reg  [1:0]       sel_sync_ff;
	reg              bo_prev_ff;
	reg              rdy_prev_ff;
	reg              aw_got_ff;
	reg              w_got_ff;
	reg  [7:0]       waddr_ff;
	reg  [31:0]      wdata_ff;
	reg  [3:0]       wstrb_ff;
	reg  [31:0]      nxt_rdata;
	reg  [1:0]       nxt_rresp;
	reg  [`IRQ_W-1:0] ev_set;
	reg  [`IRQ_W-1:0] ev_clr;
	wire             reg_ready;
	wire             brownout_flag;
	wire             awake;
	wire             do_write;
	wire             do_read;
	wire             apply;
	wire             wipe;
	wire [31:0]      status_word;

	function legal_mode;
		input [3:0] m;
		begin
			case (m)
				`MODE_PD, `MODE_DS, `MODE_STBY, `MODE_FIFO,
				`MODE_SYNRX, `MODE_RX, `MODE_WOR, `MODE_SYNTX,
				`MODE_TX: legal_mode = 1'b1;
				default:  legal_mode = 1'b0;
			endcase
		end
	endfunction

	function fifo_mode;
		input [3:0] m;
		begin
			case (m)
				`MODE_FIFO, `MODE_SYNRX, `MODE_RX,
				`MODE_SYNTX, `MODE_TX: fifo_mode = 1'b1;
				default:               fifo_mode = 1'b0;
			endcase
		end
	endfunction

	supply_seq #(
		.SETTLE_CYC (SETTLE_CYC),
		.CNT_W      (CNT_W)
	) u_supply (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.mode         (mode_cur_ff),
		.dig_on_ff    (core_dig_on),
		.ana_on_ff    (core_ana_on),
		.xtal_on_ff   (xtal_on),
		.synth_on_ff  (synth_on),
		.rx_on_ff     (rx_on),
		.tx_on_ff     (tx_on),
		.reg_ready_ff (reg_ready)
	);

	assign brownout_flag = bo_sync_ff[1];
	assign awake         = (state_ff == ST_RUN);
	assign do_write      = aw_got_ff & w_got_ff & ~s_axi_bvalid;
	assign do_read       = s_axi_arvalid & s_axi_arready;
	// fifo-less targets wait for an empty fifo before the switch
	assign apply = pend_ff & awake & (fifo_mode(mode_req_ff) | fifo_empty);
	assign wipe  = apply & (mode_req_ff == `MODE_DS);

	assign status_word = {24'h0, mode_cur_ff, fifo_access_en_ff, pend_ff,
		brownout_flag, reg_ready};

	// pin synchronisers
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bo_sync_ff  <= 2'h0;
			sel_sync_ff <= 2'h3;
		end else begin
			bo_sync_ff  <= {bo_sync_ff[0], io_below_bo};
			sel_sync_ff <= {sel_sync_ff[0], sel_n};
		end
	end

	// sleep, wake and data-out ready
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_ff     <= ST_INIT;
			init_cnt_ff  <= {CNT_W{1'b0}};
			sdo_ready_ff <= 1'b0;
		end else begin
			case (state_ff)
				ST_RUN: begin
					if (wipe) begin
						state_ff     <= ST_SLEEP;
						sdo_ready_ff <= 1'b0;
					end
				end
				ST_SLEEP: begin
					if (!sel_sync_ff[1]) begin
						state_ff    <= ST_INIT;
						init_cnt_ff <= {CNT_W{1'b0}};
					end
				end
				ST_INIT: begin
					if (init_cnt_ff == INIT_LAST) begin
						state_ff     <= ST_RUN;
						sdo_ready_ff <= 1'b1;
					end else begin
						init_cnt_ff <= init_cnt_ff + 1'b1;
					end
				end
				default: state_ff <= ST_INIT;
			endcase
		end
	end

	// mode request and applied mode
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mode_req_ff       <= `MODE_RST;
			mode_cur_ff       <= `MODE_RST;
			pend_ff           <= 1'b0;
			fifo_access_en_ff <= 1'b0;
			fifo_flush_ff     <= 1'b0;
		end else begin
			fifo_flush_ff <= 1'b0;
			if (wipe) begin
				mode_req_ff <= `MODE_RST;
				pend_ff     <= 1'b0;
			end else if (do_write && awake && waddr_ff == `OFS_MODE
				&& wstrb_ff[0] && legal_mode(wdata_ff[3:0])) begin
				mode_req_ff <= wdata_ff[3:0];
				pend_ff     <= 1'b1;
			end else if (apply) begin
				pend_ff <= 1'b0;
			end
			if (state_ff == ST_SLEEP) begin
				mode_cur_ff <= `MODE_DS;
			end else if (state_ff == ST_INIT) begin
				mode_cur_ff <= `MODE_PD;
			end else if (apply) begin
				mode_cur_ff <= mode_req_ff;
			end
			fifo_access_en_ff <= awake & fifo_mode(mode_cur_ff);
			// flush on a switch to a non-fifo mode, applied only once fifo_empty is high
			if (apply && !fifo_mode(mode_req_ff)) begin
				fifo_flush_ff <= 1'b1;
			end
		end
	end

	// interrupt events, set wins over read-clear
	always @* begin
		ev_set = {`IRQ_W{1'b0}};
		ev_set[`EV_REG_RDY] = reg_ready & ~rdy_prev_ff;
		ev_set[`EV_BROWN]   = brownout_flag & ~bo_prev_ff;
		ev_set[`EV_MODE]    = apply;
		ev_clr = {`IRQ_W{1'b0}};
		if (do_read && awake && s_axi_araddr == `OFS_IRQ_STAT) begin
			ev_clr = {`IRQ_W{1'b1}};
		end
	end

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_stat_ff <= `IRQ_RST;
			irq_mask_ff <= `IRQ_RST;
			rdy_prev_ff <= 1'b0;
			bo_prev_ff  <= 1'b0;
			irq_ff      <= 1'b0;
		end else begin
			rdy_prev_ff <= reg_ready;
			bo_prev_ff  <= brownout_flag;
			if (wipe) begin
				irq_stat_ff <= `IRQ_RST;
				irq_mask_ff <= `IRQ_RST;
			end else begin
				irq_stat_ff <= (irq_stat_ff & ~ev_clr) | ev_set;
				// a write while asleep answers an error and must not land
				if (do_write && awake && wstrb_ff[0]
					&& waddr_ff == `OFS_IRQ_MASK) begin
					irq_mask_ff <= wdata_ff[`IRQ_W-1:0];
				end
			end
			irq_ff <= |(((irq_stat_ff & ~ev_clr) | ev_set) & irq_mask_ff);
		end
	end

	// write channels, taken in either order
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			aw_got_ff     <= 1'b0;
			w_got_ff      <= 1'b0;
			waddr_ff      <= 8'h00;
			wdata_ff      <= 32'h0;
			wstrb_ff      <= 4'h0;
		end else begin
			s_axi_awready <= ~aw_got_ff & ~(s_axi_awvalid & s_axi_awready)
				& ~s_axi_bvalid;
			s_axi_wready  <= ~w_got_ff & ~(s_axi_wvalid & s_axi_wready)
				& ~s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_ff <= 1'b1;
				waddr_ff  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_got_ff    <= 1'b0;
				w_got_ff     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// asleep or initialising, nothing is written
				if (!awake || (waddr_ff != `OFS_MODE
					&& waddr_ff != `OFS_IRQ_MASK)) begin
					s_axi_bresp <= `RESP_SLVERR;
				end else begin
					s_axi_bresp <= `RESP_OKAY;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read decode
	always @* begin
		nxt_rdata = 32'h0;
		nxt_rresp = `RESP_OKAY;
		if (!awake) begin
			nxt_rresp = `RESP_SLVERR;
		end else begin
			case (s_axi_araddr)
				`OFS_MODE:     nxt_rdata = {28'h0, mode_req_ff};
				`OFS_STATUS:   nxt_rdata = status_word;
				`OFS_IRQ_STAT: nxt_rdata = {29'h0, irq_stat_ff};
				`OFS_IRQ_MASK: nxt_rdata = {29'h0, irq_mask_ff};
				default:       nxt_rresp = `RESP_SLVERR;
			endcase
		end
	end

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= ~do_read & ~s_axi_rvalid;
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= nxt_rdata;
				s_axi_rresp  <= nxt_rresp;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b0;
			end
		end
	end
endmodule

// file: test/host_model.sv
// Purpose: host side bus master for the power control block
// Assumes: AXI4-Lite, one write and one read at a time
// Notes:   slow delays rready to exercise slave hold
`timescale 1ns/100ps
module host_model (
	// clock
	input  wire         clk_sys,
	// write channels
	output logic        s_axi_awvalid,
	input  wire         s_axi_awready,
	output logic [7:0]  s_axi_awaddr,
	output logic        s_axi_wvalid,
	input  wire         s_axi_wready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0]  s_axi_wstrb,
	input  wire         s_axi_bvalid,
	output logic        s_axi_bready,
	input  wire  [1:0]  s_axi_bresp,
	// read channels
	output logic        s_axi_arvalid,
	input  wire         s_axi_arready,
	output logic [7:0]  s_axi_araddr,
	output logic        s_axi_rready,
	input  wire         s_axi_rvalid,
	input  wire  [31:0] s_axi_rdata,
	input  wire  [1:0]  s_axi_rresp
);
	int slow = 0;
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'h0;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		output logic [1:0] r);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge clk_sys);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr  <= a;
		s_axi_wvalid  <= 1'b1;
		s_axi_wdata   <= v;
		s_axi_wstrb   <= 4'hF;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready === 1'b1) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(aw && w));
		do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk_sys);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr  <= a;
		do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		repeat (slow) @(posedge clk_sys);
		s_axi_rready <= 1'b1;
		do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule

// file: test/pwr_checker.sv
// Purpose: port checker for xcvr_power_ctrl
// Assumes: one clock domain, rst async active high
// Notes:   bound into the top module, sees its ports only
`timescale 1ns/100ps
module pwr_checker #(
	parameter INIT_CYC = 2500
) (
	// clock and reset
	input wire        clk_sys,
	input wire        rst,
	// fifo side
	input wire        fifo_empty,
	input wire        fifo_flush_ff,
	input wire        fifo_access_en_ff,
	// supplies
	input wire        core_dig_on,
	input wire        core_ana_on,
	input wire        xtal_on,
	input wire        synth_on,
	input wire        rx_on,
	input wire        tx_on,
	// pins
	input wire        sel_n,
	input wire        sdo_ready_ff,
	// read data channel
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	// counts wake time; idle while asleep with select released
	int wake_cnt;
	always @(posedge clk_sys or posedge rst) begin
		if (rst)
			wake_cnt <= 0;
		else if (sdo_ready_ff)
			wake_cnt <= 0;
		else if (!sel_n || wake_cnt != 0)
			wake_cnt <= wake_cnt + 1;
	end

	sequence s_core_drop;
		$fell(core_dig_on);
	endsequence
	sequence s_rd_stall;
		s_axi_rvalid && !s_axi_rready;
	endsequence

	a_flush_one_cycle: assert property (fifo_flush_ff |=> !fifo_flush_ff)
		else $error("flush pulse too long");
	a_flush_gates_fifo: assert property (
		fifo_flush_ff |-> ##[0:1] !fifo_access_en_ff)
		else $error("fifo still accessible after flush");
	a_down_after_empty: assert property (
		s_core_drop |-> $past(fifo_empty) || $past(fifo_empty, 2))
		else $error("core off while fifo not empty");
	a_rx_full_chain: assert property (
		rx_on |-> synth_on && core_ana_on && xtal_on && core_dig_on)
		else $error("receiver on without synth and core");
	a_rx_tx_apart: assert property (!(rx_on && tx_on))
		else $error("receiver and transmitter both on");
	a_sleep_dark: assert property (
		!sdo_ready_ff [*3] |-> !core_dig_on && !xtal_on)
		else $error("supplies on while not ready");
	a_rdata_held: assert property (
		s_rd_stall |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	a_wake_bounded: assert property (wake_cnt <= INIT_CYC + 8)
		else $error("wake from sleep too slow");
endmodule

bind xcvr_power_ctrl pwr_checker #(.INIT_CYC(INIT_CYC)) pwr_checker_i (
	.clk_sys, .rst, .fifo_empty, .fifo_flush_ff, .fifo_access_en_ff,
	.core_dig_on, .core_ana_on, .xtal_on, .synth_on, .rx_on, .tx_on,
	.sel_n, .sdo_ready_ff, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// file: test/tb.sv
// Purpose: self-checking bench for xcvr_power_ctrl
// Assumes: short settle and init counts, 25 MHz clock
// Notes:   fifo and pins driven here, bus via host_model
`timescale 1ns/100ps
`include "pwr_defines.vh"
module tb;
	logic        clk_sys, rst, io_below_bo, sel_n, fifo_empty;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, sdo_ready_ff, irq_ff;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        fifo_access_en_ff, fifo_flush_ff, core_dig_on, core_ana_on;
	logic        xtal_on, synth_on, rx_on, tx_on;
	int          err_count = 0;
	int          checks_done = 0;
	int          flushes = 0;

	xcvr_power_ctrl #(.SETTLE_CYC(4), .INIT_CYC(8)) xcvr_power_ctrl_i (
		.clk_sys, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
		.s_axi_arready, .s_axi_araddr, .s_axi_rready, .s_axi_rvalid,
		.s_axi_rdata, .s_axi_rresp, .io_below_bo, .sel_n, .sdo_ready_ff,
		.fifo_empty, .fifo_access_en_ff, .fifo_flush_ff, .core_dig_on,
		.core_ana_on, .xtal_on, .synth_on, .rx_on, .tx_on, .irq_ff);
	host_model host_model_i (
		.clk_sys, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
		.s_axi_arready, .s_axi_araddr, .s_axi_rready, .s_axi_rvalid,
		.s_axi_rdata, .s_axi_rresp);

	task automatic chk(input string n, input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wrc(input logic [7:0] a, input logic [31:0] v, e);
		host_model_i.wr(a, v, r);
		chk("bresp", {30'h0, r}, e);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] v, e);
		host_model_i.rd(a, d, r);
		chk("rresp", {30'h0, r}, e);
		chk("rdata", d, v);
	endtask
	task automatic wait_sdo;
		int n;
		n = 0;
		while (sdo_ready_ff !== 1'b1 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		chk("sdo_ready", {31'h0, sdo_ready_ff}, 32'h1);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// flush pulses seen, one count per high cycle
	always @(posedge clk_sys) begin
		if (fifo_flush_ff === 1'b1) begin
			flushes++;
		end
	end

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// whole run is well under a thousand cycles
	initial begin
		#200000;
		err_count++;
		complete_run;
	end

	initial begin
		{rst, io_below_bo, sel_n, fifo_empty} = 4'hB;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		wait_sdo;
		host_model_i.slow = 2;
		rdc(`OFS_STATUS, 32'h0, `RESP_OKAY);
		rdc(8'h10, 32'h0, `RESP_SLVERR);
		wrc(`OFS_IRQ_MASK, 32'h7, `RESP_OKAY);
		host_model_i.rd(`OFS_IRQ_STAT, d, r);
		wrc(`OFS_MODE, {28'h0, `MODE_PD}, `RESP_OKAY);
		wrc(`OFS_MODE, {28'h0, `MODE_STBY}, `RESP_OKAY);
		repeat (12) @(posedge clk_sys);
		chk("xtal_on", {31'h0, xtal_on}, 32'h1);
		chk("rx_on", {31'h0, rx_on}, 32'h0);
		chk("irq", {31'h0, irq_ff}, 32'h1);
		rdc(`OFS_STATUS, 32'h51, `RESP_OKAY);
		rdc(`OFS_IRQ_STAT, 32'h5, `RESP_OKAY);
		repeat (2) @(posedge clk_sys);
		chk("irq", {31'h0, irq_ff}, 32'h0);
		wrc(`OFS_IRQ_MASK, 32'h0, `RESP_OKAY);
		io_below_bo <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk("irq", {31'h0, irq_ff}, 32'h0);
		rdc(`OFS_STATUS, 32'h53, `RESP_OKAY);
		wrc(`OFS_IRQ_MASK, 32'h2, `RESP_OKAY);
		repeat (2) @(posedge clk_sys);
		chk("irq", {31'h0, irq_ff}, 32'h1);
		rdc(`OFS_IRQ_STAT, 32'h2, `RESP_OKAY);
		io_below_bo <= 1'b0;
		wrc(`OFS_MODE, {28'h0, `MODE_RX}, `RESP_OKAY);
		repeat (4) @(posedge clk_sys);
		chk("rx_on", {31'h0, rx_on}, 32'h1);
		chk("synth_on", {31'h0, synth_on}, 32'h1);
		chk("tx_on", {31'h0, tx_on}, 32'h0);
		rdc(`OFS_STATUS, 32'h99, `RESP_OKAY);
		wrc(`OFS_MODE, 32'h3, `RESP_OKAY);
		repeat (4) @(posedge clk_sys);
		rdc(`OFS_STATUS, 32'h99, `RESP_OKAY);
		// fifo still busy, so power-down must wait
		fifo_empty <= 1'b0;
		wrc(`OFS_MODE, {28'h0, `MODE_PD}, `RESP_OKAY);
		repeat (6) @(posedge clk_sys);
		chk("core_dig", {31'h0, core_dig_on}, 32'h1);
		chk("fifo_en", {31'h0, fifo_access_en_ff}, 32'h1);
		rdc(`OFS_STATUS, 32'h9D, `RESP_OKAY);
		fifo_empty <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk("core_dig", {31'h0, core_dig_on}, 32'h0);
		chk("fifo_en", {31'h0, fifo_access_en_ff}, 32'h0);
		chk("flushes", flushes, 32'h3);
		rdc(`OFS_IRQ_MASK, 32'h2, `RESP_OKAY);
		wrc(`OFS_STATUS, 32'h0, `RESP_SLVERR);
		wrc(`OFS_MODE, {28'h0, `MODE_DS}, `RESP_OKAY);
		repeat (4) @(posedge clk_sys);
		chk("sdo_ready", {31'h0, sdo_ready_ff}, 32'h0);
		host_model_i.rd(`OFS_MODE, d, r);
		chk("rresp", {30'h0, r}, `RESP_SLVERR);
		wrc(`OFS_MODE, {28'h0, `MODE_STBY}, `RESP_SLVERR);
		wrc(`OFS_IRQ_MASK, 32'h7, `RESP_SLVERR);
		sel_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		sel_n <= 1'b1;
		wait_sdo;
		rdc(`OFS_IRQ_MASK, 32'h0, `RESP_OKAY);
		rdc(`OFS_MODE, 32'h0, `RESP_OKAY);
		wrc(`OFS_MODE, {28'h0, `MODE_STBY}, `RESP_OKAY);
		repeat (12) @(posedge clk_sys);
		wrc(`OFS_MODE, {28'h0, `MODE_TX}, `RESP_OKAY);
		repeat (4) @(posedge clk_sys);
		chk("tx_on", {31'h0, tx_on}, 32'h1);
		chk("rx_on", {31'h0, rx_on}, 32'h0);
		wrc(`OFS_MODE, {28'h0, `MODE_FIFO}, `RESP_OKAY);
		repeat (4) @(posedge clk_sys);
		chk("core_ana", {31'h0, core_ana_on}, 32'h0);
		chk("fifo_en", {31'h0, fifo_access_en_ff}, 32'h1);
		complete_run;
	end
endmodule
